//--- common/lbbs_pkg.sv
package lbbs_pkg;
   // timing
   localparam int unsigned CLK_HZ = 10_000_000;
   localparam int unsigned UNIT_MS = 100;
   localparam int unsigned UNIT_CYCLES = CLK_HZ / 1000 * UNIT_MS;
   localparam int TMR_W = 24;

   // register port
   localparam int AW = 8;
   localparam int DW = 32;
   localparam logic [7:0] ADDR_CMD = 8'h00;
   localparam logic [7:0] ADDR_RESP = 8'h04;
   localparam logic [7:0] ADDR_STAT = 8'h08;
   localparam logic [7:0] ADDR_CTRL = 8'h0c;
   localparam int STAT_BUSY = 0;
   localparam int STAT_RVLD = 1;
   localparam int STAT_IND_B = 2;
   localparam int STAT_IND_A = 3;
   localparam int STAT_BUZ = 4;
   localparam int CTRL_ABORT = 0;

   // frame layout
   localparam logic [3:0] FB_CLA = 4'h0;
   localparam logic [3:0] FB_INS = 4'h1;
   localparam logic [3:0] FB_P1 = 4'h2;
   localparam logic [3:0] FB_P2 = 4'h3;
   localparam logic [3:0] FB_LC = 4'h4;
   localparam logic [3:0] FB_DAT = 4'h5;
   localparam logic [7:0] DATA_MAX = 8'h04;
   localparam logic [3:0] DB_T1 = 4'h0;
   localparam logic [3:0] DB_T2 = 4'h1;
   localparam logic [3:0] DB_REP = 4'h2;
   localparam logic [3:0] DB_LINK = 4'h3;

   // command codes
   localparam logic [7:0] CLA_CODE = 8'hff;
   localparam logic [7:0] INS_CODE = 8'h00;
   localparam logic [7:0] P1_COMBO = 8'h40;
   localparam logic [7:0] P1_BUZ = 8'h42;
   localparam logic [7:0] P2_BUZ = 8'h00;
   localparam logic [7:0] LC_COMBO = 8'h04;
   localparam logic [7:0] LC_BUZ = 8'h03;

   // state_mask_byte fields
   localparam int MB_FIN_B = 0;
   localparam int MB_FIN_A = 1;
   localparam int MB_UPD_B = 2;
   localparam int MB_UPD_A = 3;
   localparam int MB_INI_B = 4;
   localparam int MB_INI_A = 5;
   localparam int MB_BLK_B = 6;
   localparam int MB_BLK_A = 7;

   // buzzer_link_select codes
   localparam logic [7:0] LINK_OFF = 8'h00;
   localparam logic [7:0] LINK_PH1 = 8'h01;
   localparam logic [7:0] LINK_PH2 = 8'h02;
   localparam logic [7:0] LINK_BOTH = 8'h03;

   // status words
   localparam logic [7:0] SW1_OK = 8'h90;
   localparam logic [7:0] SW1_ERR = 8'h63;
   localparam logic [7:0] SW2_ERR = 8'h00;
   localparam logic [7:0] SW2_BUZ_OK = 8'h00;
   localparam logic [15:0] RESP_RST = 16'h0000;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_PH1 = 3'b010,
      ST_PH2 = 3'b100
   } lbbs_seq_t;

   typedef enum logic [2:0] {
      K_BAD = 3'b001,
      K_COMBO = 3'b010,
      K_BUZ = 3'b100
   } lbbs_kind_t;
endpackage

//--- common/lbbs_if.sv
`timescale 1ns/1ps
interface lbbs_if;
   logic restart;
   logic tick;
   modport seq (output restart, input tick);
   modport tmr (input restart, output tick);
endinterface

//--- logic/lbbs_tick.sv
`timescale 1ns/1ps
module lbbs_tick #(
   parameter int unsigned TICK_CYCLES = lbbs_pkg::UNIT_CYCLES
) (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   // sequencer side
   lbbs_if.tmr bus
);
   import lbbs_pkg::*;

   typedef struct packed {
      logic [TMR_W-1:0] cnt;
      logic tick;
   } lbbs_tmr_t;

   lbbs_tmr_t r;
   lbbs_tmr_t n;

   // restart realigns the unit grid to the start of each phase
   always_comb begin
      n = r;
      n.tick = 1'b0;
      if (bus.restart) begin
         n.cnt = '0;
      end else if (r.cnt == TMR_W'(TICK_CYCLES - 1)) begin
         n.cnt = '0;
         n.tick = 1'b1;
      end else begin
         n.cnt = r.cnt + TMR_W'(1);
      end
   end

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign bus.tick = r.tick;
endmodule // lbbs_tick

//--- logic/lbbs_top.sv
// Behaviour
// - class ff ins 00 p1 40 lc 04 decoded
// - bit0 final b, bit1 final a
// - bits 2/3 gate steady update b/a
// - bits 4/5 initial blink level b/a
// - bits 6/7 enable blinking b/a
// - byte0 first phase, byte1 second, 100ms
// - byte2 repetitions; zero means no blink
// - byte3 buzzer link: off, ph1, ph2, both
// - success answers 90 and present levels
// - failure answers 63 00
// - final states applied after whole sequence
// - unmasked indicator keeps its steady state
// - phase times shape duty and buzzer
// - linked buzzer silent without repetitions
// - buzzer command ff 00 42 00 03
// - buzzer on, off times and repetitions
//
// Local design decisions: the strobed register port and the register addresses.
`timescale 1ns/1ps
module lbbs_top #(
   parameter int unsigned TICK_CYCLES = lbbs_pkg::UNIT_CYCLES
) (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   // register port
   input wire logic [lbbs_pkg::AW-1:0] addr_i,
   input wire logic [lbbs_pkg::DW-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [lbbs_pkg::DW-1:0] rdata_o,
   // indicators and buzzer
   output logic indicator_a_o,
   output logic indicator_b_o,
   output logic buzzer_o
);
   import lbbs_pkg::*;

   typedef struct packed {
      logic [3:0] idx;
      logic [8:0][7:0] frm;
      lbbs_seq_t st;
      logic buz_mode;
      logic [7:0] mask;
      logic [7:0] t1;
      logic [7:0] t2;
      logic [7:0] link;
      logic [7:0] rem;
      logic [7:0] pcnt;
      logic steady_a;
      logic steady_b;
      logic ind_a;
      logic ind_b;
      logic buz;
      logic [15:0] resp;
      logic resp_vld;
      logic [31:0] rdata;
      logic restart;
   } lbbs_state_t;

   lbbs_state_t r;
   lbbs_state_t n;
   logic [8:0][7:0] fb;
   logic done_w;
   logic last_w;
   lbbs_kind_t kind_w;

   lbbs_if lnk ();

   lbbs_tick #(
      .TICK_CYCLES(TICK_CYCLES)
   ) u_tick (
      .clk_sys_i(clk_sys_i),
      .reset_n_i(reset_n_i),
      .bus(lnk.tmr)
   );

   function automatic lbbs_kind_t decode_cmd(input logic [8:0][7:0] f);
      if (f[FB_CLA] == CLA_CODE && f[FB_INS] == INS_CODE &&
          f[FB_P1] == P1_COMBO && f[FB_LC] == LC_COMBO) begin
         return K_COMBO;
      end else if (f[FB_CLA] == CLA_CODE && f[FB_INS] == INS_CODE &&
                   f[FB_P1] == P1_BUZ && f[FB_P2] == P2_BUZ &&
                   f[FB_LC] == LC_BUZ) begin
         return K_BUZ;
      end
      return K_BAD;
   endfunction

   // update only when masked in, otherwise keep the present level
   function automatic logic fin_lvl(input logic upd, input logic fin,
                                    input logic cur);
      return upd ? fin : cur;
   endfunction

   function automatic logic show_lvl(input logic blk, input logic ini,
                                     input lbbs_seq_t st,
                                     input logic steady);
      if (st == ST_IDLE || !blk) begin
         return steady;
      end
      return (st == ST_PH1) ? ini : ~ini;
   endfunction

   always_comb begin
      n = r;
      n.restart = 1'b0;
      n.rdata = '0;
      fb = r.frm;
      fb[r.idx] = wdata_i[7:0];
      kind_w = decode_cmd(fb);
      last_w = 1'b0;
      done_w = 1'b0;
      if (r.idx == FB_LC) begin
         // too long a frame cannot be held, so it ends here as a failure
         last_w = (wdata_i[7:0] == 8'h00) || (wdata_i[7:0] > DATA_MAX);
      end else if (r.idx > FB_LC) begin
         last_w = 8'(r.idx) == 8'(FB_LC) + r.frm[FB_LC];
      end
      if (wr_i && addr_i == ADDR_CMD) begin
         n.frm = fb;
         if (last_w) begin
            done_w = 1'b1;
            n.idx = '0;
         end else begin
            n.idx = r.idx + 4'h1;
         end
      end
      // phase sequencer; a zero length phase lasts one cycle
      // a tick left over from before a restart is dropped, else a unit is lost
      case (r.st)
         ST_IDLE: begin
         end
         ST_PH1: begin
            if (r.pcnt == 8'h00) begin
               n.st = ST_PH2;
               n.pcnt = r.t2;
               n.restart = 1'b1;
            end else if (lnk.tick && !r.restart) begin
               n.pcnt = r.pcnt - 8'h01;
            end
         end
         ST_PH2: begin
            if (r.pcnt == 8'h00) begin
               if (r.rem <= 8'h01) begin
                  n.st = ST_IDLE;
                  n.steady_a = fin_lvl(r.mask[MB_UPD_A], r.mask[MB_FIN_A],
                                       r.steady_a);
                  n.steady_b = fin_lvl(r.mask[MB_UPD_B], r.mask[MB_FIN_B],
                                       r.steady_b);
               end else begin
                  n.rem = r.rem - 8'h01;
                  n.st = ST_PH1;
                  n.pcnt = r.t1;
                  n.restart = 1'b1;
               end
            end else if (lnk.tick && !r.restart) begin
               n.pcnt = r.pcnt - 8'h01;
            end
         end
         default: begin
            n.st = ST_IDLE;
         end
      endcase
      // abort last, so that it beats a phase change in the same cycle
      if (wr_i && addr_i == ADDR_CTRL && wdata_i[CTRL_ABORT]) begin
         n.idx = '0;
         n.st = ST_IDLE;
      end
      // a command while a sequence runs is refused rather than queued
      if (done_w) begin
         n.resp_vld = 1'b1;
         if (r.st != ST_IDLE || kind_w == K_BAD) begin
            n.resp = {SW1_ERR, SW2_ERR};
         end else if (kind_w == K_COMBO) begin
            n.buz_mode = 1'b0;
            n.mask = fb[FB_P2];
            n.t1 = fb[FB_DAT + DB_T1];
            n.t2 = fb[FB_DAT + DB_T2];
            n.rem = fb[FB_DAT + DB_REP];
            n.link = fb[FB_DAT + DB_LINK];
            if (fb[FB_DAT + DB_REP] == 8'h00) begin
               // no sequence: final states take effect at once
               n.steady_a = fin_lvl(fb[FB_P2][MB_UPD_A], fb[FB_P2][MB_FIN_A],
                                    r.steady_a);
               n.steady_b = fin_lvl(fb[FB_P2][MB_UPD_B], fb[FB_P2][MB_FIN_B],
                                    r.steady_b);
               n.resp = {SW1_OK, 6'h00, n.steady_a, n.steady_b};
            end else begin
               n.st = ST_PH1;
               n.pcnt = fb[FB_DAT + DB_T1];
               n.restart = 1'b1;
               n.resp = {SW1_OK, 6'h00, r.steady_a, r.steady_b};
            end
         end else begin
            n.buz_mode = 1'b1;
            n.mask = 8'h00;
            n.link = LINK_PH1;
            n.t1 = fb[FB_DAT + DB_T1];
            n.t2 = fb[FB_DAT + DB_T2];
            n.rem = fb[FB_DAT + DB_REP];
            n.resp = {SW1_OK, SW2_BUZ_OK};
            if (fb[FB_DAT + DB_REP] != 8'h00) begin
               n.st = ST_PH1;
               n.pcnt = fb[FB_DAT + DB_T1];
               n.restart = 1'b1;
            end
         end
      end else if (rd_i && addr_i == ADDR_RESP) begin
         n.resp_vld = 1'b0;
      end
      n.ind_a = show_lvl(n.mask[MB_BLK_A], n.mask[MB_INI_A], n.st,
                         n.steady_a);
      n.ind_b = show_lvl(n.mask[MB_BLK_B], n.mask[MB_INI_B], n.st,
                         n.steady_b);
      // idle forces silence, so zero repetitions never sound it
      if (n.st == ST_IDLE) begin
         n.buz = 1'b0;
      end else if (n.buz_mode) begin
         n.buz = (n.st == ST_PH1);
      end else begin
         n.buz = (n.st == ST_PH1 && (n.link == LINK_PH1 ||
                                     n.link == LINK_BOTH)) ||
                 (n.st == ST_PH2 && (n.link == LINK_PH2 ||
                                     n.link == LINK_BOTH));
      end
      if (rd_i) begin
         case (addr_i)
            ADDR_RESP: begin
               n.rdata[15:0] = r.resp;
            end
            ADDR_STAT: begin
               n.rdata[STAT_BUSY] = (r.st != ST_IDLE);
               n.rdata[STAT_RVLD] = r.resp_vld;
               n.rdata[STAT_IND_B] = r.ind_b;
               n.rdata[STAT_IND_A] = r.ind_a;
               n.rdata[STAT_BUZ] = r.buz;
            end
            default: begin
               n.rdata = '0;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         r <= '0;
         r.st <= ST_IDLE;
         r.resp <= RESP_RST;
      end else begin
         r <= n;
      end
   end

   assign lnk.restart = r.restart;
   assign rdata_o = r.rdata;
   assign indicator_a_o = r.ind_a;
   assign indicator_b_o = r.ind_b;
   assign buzzer_o = r.buz;

   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!reset_n_i);
   sequence s_last_phase;
      r.st == ST_PH2 && r.rem == 8'h01 && r.pcnt == 8'h00;
   endsequence
   sequence s_combo_start;
      done_w && kind_w == K_COMBO && r.st == ST_IDLE &&
         fb[FB_DAT + DB_REP] != 8'h00;
   endsequence
   property p_resp_ok;
      s_combo_start |=> r.resp_vld &&
         r.resp == {SW1_OK, 6'h00, $past(r.steady_a), $past(r.steady_b)};
   endproperty
   a_resp_ok: assert property (p_resp_ok)
      else $error("success response wrong");
   property p_resp_err;
      done_w && (kind_w == K_BAD || r.st != ST_IDLE) |=>
         r.resp == {SW1_ERR, SW2_ERR} && r.resp_vld;
   endproperty
   a_resp_err: assert property (p_resp_err)
      else $error("failure response wrong");
   property p_buz_cmd;
      done_w && kind_w == K_BUZ && r.st == ST_IDLE |=>
         r.resp == {SW1_OK, SW2_BUZ_OK} && r.buz_mode;
   endproperty
   a_buz_cmd: assert property (p_buz_cmd)
      else $error("buzzer command not taken");
   property p_start_ph1;
      s_combo_start |=> r.st == ST_PH1 && r.pcnt == $past(fb[FB_DAT + DB_T1])
         && indicator_a_o == ($past(fb[FB_P2][MB_BLK_A]) ?
                              $past(fb[FB_P2][MB_INI_A]) : r.steady_a);
   endproperty
   a_start_ph1: assert property (p_start_ph1)
      else $error("first phase did not start with initial level");
   property p_ph2_toggle;
      r.st == ST_PH2 && r.mask[MB_BLK_B] |->
         indicator_b_o == ~r.mask[MB_INI_B];
   endproperty
   a_ph2_toggle: assert property (p_ph2_toggle)
      else $error("second phase level not toggled");
   property p_no_blink;
      r.st != ST_IDLE && !r.mask[MB_BLK_A] |-> indicator_a_o == r.steady_a;
   endproperty
   a_no_blink: assert property (p_no_blink)
      else $error("indicator a blinks without enable");
   property p_buz_idle;
      r.st == ST_IDLE |-> !buzzer_o;
   endproperty
   a_buz_idle: assert property (p_buz_idle)
      else $error("buzzer sounds outside a sequence");
   property p_buz_link;
      r.st == ST_PH2 && !r.buz_mode && r.link == LINK_PH1 |-> !buzzer_o;
   endproperty
   a_buz_link: assert property (p_buz_link)
      else $error("buzzer sounds in unlinked phase");
   property p_final;
      s_last_phase ##0 !(wr_i && addr_i == ADDR_CTRL) |=>
         r.st == ST_IDLE &&
         indicator_a_o == ($past(r.mask[MB_UPD_A]) ? $past(r.mask[MB_FIN_A])
                           : $past(r.steady_a)) &&
         indicator_b_o == ($past(r.mask[MB_UPD_B]) ? $past(r.mask[MB_FIN_B])
                           : $past(r.steady_b));
   endproperty
   a_final: assert property (p_final)
      else $error("final state not applied after sequence");
   property p_phase2_len;
      r.st == ST_PH1 && r.pcnt == 8'h00 && !(wr_i && addr_i == ADDR_CTRL)
         |=> r.st == ST_PH2 && r.pcnt == $past(r.t2) && lnk.restart
         ##1 (!lnk.restart || r.t2 == 8'h00);
   endproperty
   a_phase2_len: assert property (p_phase2_len)
      else $error("second phase length not loaded");
endmodule // lbbs_top

//--- dv/lbbs_host_model.sv
`timescale 1ns/1ps
module lbbs_host_model (
   // clock
   input wire logic clk_sys_i,
   // register port master
   output logic [lbbs_pkg::AW-1:0] addr_o,
   output logic [lbbs_pkg::DW-1:0] wdata_o,
   output logic wr_o,
   output logic rd_o,
   input wire logic [lbbs_pkg::DW-1:0] rdata_i
);
   import lbbs_pkg::*;
   initial begin
      addr_o = 8'h00;
      wdata_o = 32'h0;
      wr_o = 1'b0;
      rd_o = 1'b0;
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys_i);
      addr_o <= a;
      wdata_o <= d;
      wr_o <= 1'b1;
      @(posedge clk_sys_i);
      wr_o <= 1'b0;
   endtask
   // data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_sys_i);
      addr_o <= a;
      rd_o <= 1'b1;
      @(posedge clk_sys_i);
      rd_o <= 1'b0;
      @(posedge clk_sys_i);
      d = rdata_i;
   endtask
   // one byte per command write, class byte first
   task automatic send(input logic [7:0] f[$]);
      foreach (f[i]) wr(ADDR_CMD, {24'h0, f[i]});
   endtask
endmodule // lbbs_host_model

//--- dv/tb_led_buzzer_blink_sequencer.sv
`timescale 1ns/1ps
module tb_led_buzzer_blink_sequencer;
   import lbbs_pkg::*;
   typedef struct {logic [7:0] mask; logic [7:0] sw2;} lbbs_row_t;
   logic clk_sys_i, reset_n_i, wr_i, rd_i, buz_q;
   logic indicator_a_o, indicator_b_o, buzzer_o;
   logic [AW-1:0] addr_i;
   logic [DW-1:0] wdata_i, rdata_o;
   logic [31:0] d;
   int mismatches, total_checks, buz_hi, buz_rise, h0, r0;
   lbbs_row_t rows[5] = '{'{8'h0f, 8'h03}, '{8'h04, 8'h02},
      '{8'h00, 8'h02}, '{8'h0c, 8'h00}, '{8'hcb, 8'h02}};

   lbbs_host_model host (.clk_sys_i(clk_sys_i), .addr_o(addr_i),
      .wdata_o(wdata_i), .wr_o(wr_i), .rd_o(rd_i), .rdata_i(rdata_o));
   lbbs_top #(.TICK_CYCLES(4)) dut (.clk_sys_i(clk_sys_i),
      .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .indicator_a_o(indicator_a_o), .indicator_b_o(indicator_b_o),
      .buzzer_o(buzzer_o));

   initial begin
      clk_sys_i = 1'b0;
      forever #50 clk_sys_i = ~clk_sys_i;
   end
   initial begin
      buz_q = 1'b0;
      buz_hi = 0;
      buz_rise = 0;
   end
   always @(posedge clk_sys_i) begin
      buz_q <= buzzer_o;
      if (buzzer_o === 1'b1) buz_hi++;
      if (buzzer_o === 1'b1 && buz_q !== 1'b1) buz_rise++;
   end
   // generous: the whole run needs about 600 cycles
   initial begin
      repeat (20000) @(posedge clk_sys_i);
      mismatches++;
      give_verdict;
   end

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chk_rng(string n, int lo, int hi, int g);
      total_checks++;
      if (g < lo || g > hi) begin
         mismatches++;
         $display("ERROR %s expected %0d..%0d seen %0d", n, lo, hi, g);
      end
   endtask
   task automatic frame(logic [7:0] m, t1, t2, rep, lnk);
      h0 = buz_hi;
      r0 = buz_rise;
      host.send('{CLA_CODE, INS_CODE, P1_COMBO, m, LC_COMBO,
         t1, t2, rep, lnk});
   endtask
   task automatic resp(logic [7:0] sw1, logic [7:0] sw2);
      host.rd(ADDR_RESP, d);
      chk("resp", {16'h0, sw1, sw2}, d & 32'hffff);
   endtask
   task automatic wait_idle;
      for (int i = 0; i < 300; i++) begin
         host.rd(ADDR_STAT, d);
         if (d[STAT_BUSY] === 1'b0) break;
      end
      chk("busy", 32'h0, {31'h0, d[STAT_BUSY]});
   endtask
   task automatic lamps(logic a, logic b);
      chk("ind_a", {31'h0, a}, {31'h0, indicator_a_o});
      chk("ind_b", {31'h0, b}, {31'h0, indicator_b_o});
   endtask
   task automatic buz(int lo, int hi);
      chk_rng("buz_hi", lo, hi, buz_hi - h0);
   endtask

   initial begin
      reset_n_i = 1'b0;
      repeat (12) @(posedge clk_sys_i);
      reset_n_i <= 1'b1;
      @(posedge clk_sys_i);
      lamps(1'b0, 1'b0);
      host.rd(ADDR_STAT, d);
      chk("stat", 32'h0, d);
      // steady-state rows, no repetitions, buzzer linked to both phases
      foreach (rows[i]) begin
         frame(rows[i].mask, 8'h01, 8'h01, 8'h00, LINK_BOTH);
         resp(SW1_OK, rows[i].sw2);
         lamps(rows[i].sw2[1], rows[i].sw2[0]);
         buz(0, 0);
      end
      host.rd(ADDR_STAT, d);
      chk("rvld", 32'h0, {31'h0, d[STAT_RVLD]});
      host.rd(8'h10, d);
      chk("unmapped", 32'h0, d);
      // indicator b blinks twice, buzzer in first phases
      frame(8'h50, 8'h02, 8'h03, 8'h02, LINK_PH1);
      resp(SW1_OK, 8'h02);
      for (int r = 0; r < 2; r++) begin
         for (int i = 0; i < 30 && indicator_b_o !== 1'b1; i++)
            @(posedge clk_sys_i);
         lamps(1'b1, 1'b1);
         for (int i = 0; i < 30 && indicator_b_o !== 1'b0; i++)
            @(posedge clk_sys_i);
         repeat (2) @(posedge clk_sys_i);
         chk("buz_ph2", 32'h0, {31'h0, buzzer_o});
      end
      wait_idle;
      lamps(1'b1, 1'b0);
      buz(16, 22);
      chk("buz_rise", 32'd2, buz_rise - r0);
      // each buzzer link code and one unused code, lamps left alone
      for (int k = 0; k < 5; k++) begin
         frame(8'h00, 8'h01, 8'h03, 8'h01, k[7:0]);
         resp(SW1_OK, 8'h02);
         wait_idle;
         buz((k[0] ? 4 : 0) + (k[1] ? 12 : 0),
            (k[0] ? 7 : 0) + (k[1] ? 15 : 0));
         lamps(1'b1, 1'b0);
      end
      // new steady levels wait for the end of the sequence
      frame(8'h8f, 8'h02, 8'h02, 8'h01, LINK_OFF);
      resp(SW1_OK, 8'h02);
      lamps(1'b0, 1'b0);
      wait_idle;
      lamps(1'b1, 1'b1);
      h0 = buz_hi;
      r0 = buz_rise;
      host.send('{CLA_CODE, INS_CODE, P1_BUZ, P2_BUZ, LC_BUZ,
         8'h02, 8'h01, 8'h02});
      resp(SW1_OK, SW2_BUZ_OK);
      wait_idle;
      buz(16, 22);
      chk("buz_rise", 32'd2, buz_rise - r0);
      lamps(1'b1, 1'b1);
      host.send('{CLA_CODE, INS_CODE, 8'h41, 8'h00, 8'h00});
      resp(SW1_ERR, SW2_ERR);
      host.send('{CLA_CODE, INS_CODE, P1_BUZ, 8'h01, LC_BUZ,
         8'h01, 8'h01, 8'h01});
      resp(SW1_ERR, SW2_ERR);
      // a command while busy is refused, then abort
      frame(8'h00, 8'h14, 8'h00, 8'h01, LINK_PH1);
      resp(SW1_OK, 8'h03);
      frame(8'h0c, 8'h00, 8'h00, 8'h00, LINK_OFF);
      resp(SW1_ERR, SW2_ERR);
      chk("buz_on", 32'h1, {31'h0, buzzer_o});
      host.rd(ADDR_STAT, d);
      chk("stat_busy", 32'h1d, d);
      host.wr(ADDR_CTRL, 32'h1);
      wait_idle;
      chk("buz_off", 32'h0, {31'h0, buzzer_o});
      lamps(1'b1, 1'b1);
      // reset in the middle of a sequence
      frame(8'hf0, 8'h05, 8'h05, 8'h03, LINK_BOTH);
      @(posedge clk_sys_i);
      reset_n_i <= 1'b0;
      repeat (3) @(posedge clk_sys_i);
      lamps(1'b0, 1'b0);
      chk("buz_rst", 32'h0, {31'h0, buzzer_o});
      reset_n_i <= 1'b1;
      @(posedge clk_sys_i);
      lamps(1'b0, 1'b0);
      host.rd(ADDR_STAT, d);
      chk("stat_rst", 32'h0, d);
      give_verdict;
   end
endmodule // tb_led_buzzer_blink_sequencer
